// ---- hdl/pcs_pkg.sv ----
// Shared constants and types of the PWM switching clock controller.
package pcs_pkg;
   // ----------------------------------------------------------------
   // Register map
   // ----------------------------------------------------------------
   localparam int ADDR_W = 6;
   localparam logic [5:0] OFF_FREQ_SEL = 6'h00;
   localparam logic [5:0] OFF_SYNC_MODE = 6'h04;
   localparam logic [5:0] OFF_WIN_PCT = 6'h08;
   localparam logic [5:0] OFF_EXP_CNT = 6'h0C;
   localparam logic [5:0] OFF_DUTY_LIM0 = 6'h10;
   localparam logic [5:0] OFF_STATUS = 6'h20;
   localparam int NUM_CH = 4;
   // ----------------------------------------------------------------
   // Field positions
   // ----------------------------------------------------------------
   localparam int FS_OSC_LSB = 4;
   localparam int FS_DIV_LSB = 0;
   localparam int SM_EXT_BIT = 0;
   localparam int SM_SLAVE_BIT = 1;
   localparam int SM_AUTO_BIT = 2;
   localparam int SM_MASTER_BIT = 3;
   localparam int ST_STATE_LSB = 0;
   localparam int ST_EXT_OK_BIT = 2;
   localparam int ST_EXT_FAIL_BIT = 3;
   localparam int ST_UNSUP_BIT = 4;
   localparam int ST_LOADED_BIT = 5;
   localparam int ST_COUNT_LSB = 16;
   // ----------------------------------------------------------------
   // Reset values
   // ----------------------------------------------------------------
   localparam logic [7:0] FREQ_SEL_RST = 8'h11;
   localparam logic [7:0] SYNC_MODE_RST = 8'h00;
   localparam logic [7:0] WIN_PCT_RST = 8'h05;
   localparam logic [15:0] EXP_CNT_RST = 16'h0000;
   localparam logic [7:0] DUTY_LIM_RST = 8'h64;
   // ----------------------------------------------------------------
   // Timing and frequency figures
   // ----------------------------------------------------------------
   localparam int OSC_TOP_KHZ = 48000;
   localparam int OSC_STEP_KHZ = 3200;
   localparam int MIN_FSW_KHZ = 300;
   localparam int CYC_PER_DIV = 16;
   localparam int SAMPLE_CYC = 16;
   localparam int MIN_ON_NS = 40;
   localparam int NS_PER_S_BY_KHZ = 1000000;
   localparam int PCT_FULL = 100;
   localparam int DUTY_SHIFT = 8;
   localparam int MEAS_CYC_DEF = 256;

   // Clock source states.
   typedef enum logic [1:0] {CS_LOAD, CS_INT, CS_EXT} pcs_clk_state_t;

   // Main oscillator frequency in kHz for a three-bit code.
   function automatic int pcs_osc_khz(input logic [2:0] code);
      return OSC_TOP_KHZ - OSC_STEP_KHZ * int'(code);
   endfunction : pcs_osc_khz
endpackage : pcs_pkg

// ---- hdl/pcs_tim_if.sv ----
// Period timing shared between the controller and its PWM channels.
`timescale 1ns/1ns
interface pcs_tim_if;
   logic [7:0] cnt;     // Position inside the period, in oscillator ticks.
   logic [7:0] period;  // Period length in ticks.
   logic [7:0] max_on;  // Longest on time leaving the sampling window.
   logic [7:0] min_on;  // Shortest allowed on pulse.
   logic start;         // First tick of a period.
   logic run;           // Switching allowed.
   modport ctrl (output cnt, period, max_on, min_on, start, run);
   modport chan (input cnt, period, max_on, min_on, start, run);
endinterface : pcs_tim_if

// ---- hdl/pcs_pwm_chan.sv ----
// One PWM channel with on-time limits and duty clamp.
`timescale 1ns/1ns
module pcs_pwm_chan (
   input wire logic sys_clk_i,     // System clock.
   input wire logic rst_i,         // Asynchronous reset, active high.
   pcs_tim_if.chan tim,            // Period timing.
   input wire logic [7:0] duty_cmd_i, // Requested duty, units of 1/256.
   input wire logic [7:0] duty_lim_i, // Duty limit in percent.
   output logic hs_o,              // High-side drive.
   output logic ls_o,              // Low-side drive.
   output logic clamped_o          // Duty was clamped this period.
);
   logic [15:0] req_prod;
   logic [15:0] lim_prod;
   logic [7:0] req_on;
   logic [7:0] lim_on;
   logic [7:0] on_next;
   logic clamp_next;
   logic [7:0] on_reg;

   // Work out the on time for the coming period.
   always_comb begin
      req_prod = duty_cmd_i * tim.period;
      lim_prod = (duty_lim_i * tim.period) / 16'(pcs_pkg::PCT_FULL);
      req_on = req_prod[15:8];
      lim_on = lim_prod[7:0];
      on_next = req_on;
      clamp_next = 1'b0;
      if (on_next >= lim_on) begin
         on_next = lim_on;
         clamp_next = (req_on != 8'h00);
      end
      if (on_next > tim.max_on) begin
         on_next = tim.max_on;
         clamp_next = 1'b1;
      end
      if (on_next != 8'h00 && on_next < tim.min_on) begin
         on_next = tim.min_on;
      end
   end

   // Latch the on time once per period.
   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         on_reg <= 8'h00;
         clamped_o <= 1'b0;
      end else if (tim.start) begin
         on_reg <= tim.run ? on_next : 8'h00;
         clamped_o <= tim.run & clamp_next;
      end
   end

   // Drive the switches; while running, low side takes every tick the high side does not.
   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         hs_o <= 1'b0;
         ls_o <= 1'b0;
      end else begin
         hs_o <= tim.run && (tim.cnt < on_reg);
         ls_o <= tim.run && !(tim.cnt < on_reg);
      end
   end

   default clocking cb @(posedge sys_clk_i);
   endclocking
   default disable iff (rst_i);

   min_pulse_a: assert property (on_reg == 8'h00 || on_reg >= tim.min_on)
      else $error("on pulse shorter than minimum");
   sample_gap_a: assert property (tim.start |=> on_reg + 8'(pcs_pkg::SAMPLE_CYC) <= tim.period)
      else $error("low-side sampling window too short");
   duty_clamp_a: assert property (tim.start && tim.run |=> on_reg <= $past(lim_on)
      || on_reg == $past(tim.min_on))
      else $error("duty not clamped at limit");
endmodule : pcs_pwm_chan

// ---- hdl/pcs_top.sv ----
// Switching clock controller: frequency select, duty limits, clock sync.
`timescale 1ns/1ns
module pcs_top #(
   parameter int MEAS_CYC = pcs_pkg::MEAS_CYC_DEF  // Measurement interval in ticks.
) (
   input wire logic sys_clk_i,        // System clock, 10 MHz.
   input wire logic rst_i,            // Asynchronous reset, active high.
   input wire logic psel,             // APB select.
   input wire logic penable,          // APB enable.
   input wire logic pwrite,           // APB write.
   input wire logic [31:0] paddr,     // APB address.
   input wire logic [31:0] pwdata,    // APB write data.
   output logic [31:0] prdata,        // APB read data.
   output logic pready,               // APB ready.
   output logic pslverr,              // APB error.
   input wire logic cfg_loaded_i,     // Configuration memory loaded (pin).
   input wire logic ext_clk_i,        // External clock on the GPIO input.
   input wire logic [31:0] duty_cmd_i, // Four duty demands, 8 bits each.
   output logic [3:0] hs_o,           // High-side drives.
   output logic [3:0] ls_o,           // Low-side drives.
   output logic [3:0] clamped_o,      // Duty clamp flags.
   output logic main_clk_ext_o,       // Main clock taken from external.
   output logic clk_out_o,            // Forwarded clock to a slave.
   output logic sync_out_o            // Phase sync to a slave.
);
   // ----------------------------------------------------------------
   // Registers and bus slave
   // ----------------------------------------------------------------
   logic [7:0] freq_sel_reg;
   logic [7:0] sync_mode_reg;
   logic [7:0] win_pct_reg;
   logic [15:0] exp_cnt_reg;
   logic [7:0] duty_lim_reg [pcs_pkg::NUM_CH];
   logic [31:0] status;
   logic [31:0] rd_next;
   logic mapped;
   logic wr_en;
   logic [5:0] addr;
   pcs_pkg::pcs_clk_state_t state_reg;
   pcs_pkg::pcs_clk_state_t state_next;

   assign addr = paddr[5:0];
   assign wr_en = psel & penable & pwrite & mapped;
   assign pready = penable;
   assign pslverr = psel & penable & !mapped;

   // Decode the address and select read data.
   always_comb begin
      mapped = (paddr[31:6] == 26'h0000000) && (addr[1:0] == 2'h0) &&
               (addr <= pcs_pkg::OFF_STATUS);
      rd_next = 32'h00000000;
      unique case (addr)
         pcs_pkg::OFF_FREQ_SEL: rd_next = {24'h000000, freq_sel_reg};
         pcs_pkg::OFF_SYNC_MODE: rd_next = {24'h000000, sync_mode_reg};
         pcs_pkg::OFF_WIN_PCT: rd_next = {24'h000000, win_pct_reg};
         pcs_pkg::OFF_EXP_CNT: rd_next = {16'h0000, exp_cnt_reg};
         pcs_pkg::OFF_STATUS: rd_next = status;
         default: begin
            if (addr >= pcs_pkg::OFF_DUTY_LIM0 && addr < pcs_pkg::OFF_STATUS) begin
               rd_next = {24'h000000, duty_lim_reg[addr[3:2]]};
            end
         end
      endcase
   end

   // Read data is captured in the setup phase and shown in the access phase.
   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         prdata <= 32'h00000000;
      end else if (psel && !penable && !pwrite) begin
         prdata <= rd_next;
      end
   end

   // Software-written configuration.
   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         freq_sel_reg <= pcs_pkg::FREQ_SEL_RST;
         sync_mode_reg <= pcs_pkg::SYNC_MODE_RST;
         win_pct_reg <= pcs_pkg::WIN_PCT_RST;
         exp_cnt_reg <= pcs_pkg::EXP_CNT_RST;
         for (int i = 0; i < pcs_pkg::NUM_CH; i++) begin
            duty_lim_reg[i] <= pcs_pkg::DUTY_LIM_RST;
         end
      end else if (wr_en) begin
         if (addr == pcs_pkg::OFF_FREQ_SEL) begin
            freq_sel_reg <= {1'b0, pwdata[6:4], 1'b0, pwdata[2:0]};
         end
         if (addr == pcs_pkg::OFF_SYNC_MODE) begin
            sync_mode_reg <= {4'h0, pwdata[3:0]};
         end
         if (addr == pcs_pkg::OFF_WIN_PCT) begin
            win_pct_reg <= pwdata[7:0];
         end
         if (addr == pcs_pkg::OFF_EXP_CNT) begin
            exp_cnt_reg <= pwdata[15:0];
         end
         if (addr >= pcs_pkg::OFF_DUTY_LIM0 && addr < pcs_pkg::OFF_STATUS) begin
            duty_lim_reg[addr[3:2]] <= pwdata[7:0];
         end
      end
   end

   // ----------------------------------------------------------------
   // Frequency and period
   // ----------------------------------------------------------------
   logic [2:0] osc_code;
   logic [2:0] div_code;
   logic unsupported;
   logic [7:0] cnt_reg;
   logic [7:0] act_sel_reg;
   pcs_tim_if tim ();

   assign osc_code = act_sel_reg[pcs_pkg::FS_OSC_LSB +: 3];
   assign div_code = act_sel_reg[pcs_pkg::FS_DIV_LSB +: 3];
   // Too slow means the oscillator is below 300 kHz times the divided period.
   assign unsupported = (div_code == 3'h0) || (pcs_pkg::pcs_osc_khz(osc_code) <
      pcs_pkg::MIN_FSW_KHZ * pcs_pkg::CYC_PER_DIV * (int'(div_code) + 1));
   assign tim.period = 8'(pcs_pkg::CYC_PER_DIV * (int'(div_code) + 1));
   assign tim.max_on = tim.period - 8'(pcs_pkg::SAMPLE_CYC);
   // Shortest pulse in oscillator ticks, rounded up.
   assign tim.min_on = 8'((pcs_pkg::MIN_ON_NS * pcs_pkg::pcs_osc_khz(osc_code) +
      pcs_pkg::NS_PER_S_BY_KHZ - 1) / pcs_pkg::NS_PER_S_BY_KHZ);
   assign tim.run = !unsupported && (state_reg != pcs_pkg::CS_LOAD);
   assign tim.cnt = cnt_reg;
   assign tim.start = (cnt_reg == 8'h00);

   // Period counter; one tick stands for one main oscillator cycle.
   // A new frequency select takes effect only at a period boundary, so that the period
   // length and the on times latched for it always belong to one setting.
   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         cnt_reg <= 8'h00;
         act_sel_reg <= pcs_pkg::FREQ_SEL_RST;
      end else if (cnt_reg >= tim.period - 8'h01) begin
         cnt_reg <= 8'h00;
         act_sel_reg <= freq_sel_reg;
      end else begin
         cnt_reg <= cnt_reg + 8'h01;
      end
   end

   // One channel per output.
   for (genvar g = 0; g < pcs_pkg::NUM_CH; g++) begin : g_ch
      pcs_pwm_chan u_chan (
         .sys_clk_i (sys_clk_i),
         .rst_i (rst_i),
         .tim (tim),
         .duty_cmd_i (duty_cmd_i[8*g +: 8]),
         .duty_lim_i (duty_lim_reg[g]),
         .hs_o (hs_o[g]),
         .ls_o (ls_o[g]),
         .clamped_o (clamped_o[g])
      );
   end

   // ----------------------------------------------------------------
   // Pin synchronisers and frequency detector
   // ----------------------------------------------------------------
   logic ld_s1_reg;
   logic ld_s2_reg;
   logic ext_s1_reg;
   logic ext_s2_reg;
   logic ext_d_reg;
   logic [15:0] meas_reg;
   logic [15:0] edge_reg;
   logic [15:0] last_cnt_reg;
   logic meas_done;
   logic win_ok;
   logic [15:0] diff;
   logic ext_ok_reg;
   logic ext_fail_reg;

   // Two flip-flops for each asynchronous pin.
   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         ld_s1_reg <= 1'b0;
         ld_s2_reg <= 1'b0;
         ext_s1_reg <= 1'b0;
         ext_s2_reg <= 1'b0;
         ext_d_reg <= 1'b0;
      end else begin
         ld_s1_reg <= cfg_loaded_i;
         ld_s2_reg <= ld_s1_reg;
         ext_s1_reg <= ext_clk_i;
         ext_s2_reg <= ext_s1_reg;
         ext_d_reg <= ext_s2_reg;
      end
   end

   assign meas_done = (meas_reg == 16'(MEAS_CYC - 1));
   assign diff = (edge_reg > exp_cnt_reg) ? edge_reg - exp_cnt_reg : exp_cnt_reg - edge_reg;
   // In window when edges were seen and the error is within the percentage.
   assign win_ok = (edge_reg != 16'h0000) &&
      (32'(diff) * 32'(pcs_pkg::PCT_FULL) <= 32'(exp_cnt_reg) * 32'(win_pct_reg));

   // Count external rising edges over each measurement interval.
   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         meas_reg <= 16'h0000;
         edge_reg <= 16'h0000;
         last_cnt_reg <= 16'h0000;
         ext_ok_reg <= 1'b0;
      end else if (meas_done) begin
         meas_reg <= 16'h0000;
         edge_reg <= 16'h0000;
         last_cnt_reg <= edge_reg;
         ext_ok_reg <= win_ok;
      end else begin
         meas_reg <= meas_reg + 16'h0001;
         if (ext_s2_reg && !ext_d_reg && edge_reg != 16'hFFFF) begin
            edge_reg <= edge_reg + 16'h0001;
         end
      end
   end

   // ----------------------------------------------------------------
   // Clock source selection
   // ----------------------------------------------------------------
   logic want_ext;
   logic auto_back;
   logic master;

   assign want_ext = sync_mode_reg[pcs_pkg::SM_EXT_BIT] | sync_mode_reg[pcs_pkg::SM_SLAVE_BIT];
   assign auto_back = sync_mode_reg[pcs_pkg::SM_AUTO_BIT];
   assign master = sync_mode_reg[pcs_pkg::SM_MASTER_BIT];

   // Next clock source.
   always_comb begin
      state_next = state_reg;
      unique case (state_reg)
         pcs_pkg::CS_LOAD: begin
            if (ld_s2_reg) begin
               state_next = pcs_pkg::CS_INT;
            end
         end
         pcs_pkg::CS_INT: begin
            if (want_ext && meas_done && win_ok) begin
               state_next = pcs_pkg::CS_EXT;
            end
         end
         pcs_pkg::CS_EXT: begin
            if (!want_ext || (meas_done && !win_ok && auto_back)) begin
               state_next = pcs_pkg::CS_INT;
            end
         end
         default: state_next = pcs_pkg::CS_INT;
      endcase
   end

   // Source state; reset always lands in the load state, CS_LOAD.
   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         state_reg <= pcs_pkg::CS_LOAD;
      end else begin
         state_reg <= state_next;
      end
   end

   // External failure flag: set on a bad interval while external, cleared on switch-in.
   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         ext_fail_reg <= 1'b0;
      end else if (state_reg == pcs_pkg::CS_EXT && meas_done && !win_ok) begin
         ext_fail_reg <= 1'b1;
      end else if (state_reg == pcs_pkg::CS_INT && state_next == pcs_pkg::CS_EXT) begin
         ext_fail_reg <= 1'b0;
      end
   end

   // Clock select and master outputs, only once configuration is loaded.
   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         main_clk_ext_o <= 1'b0;
         clk_out_o <= 1'b0;
         sync_out_o <= 1'b0;
      end else begin
         main_clk_ext_o <= (state_next == pcs_pkg::CS_EXT);
         clk_out_o <= master && state_reg != pcs_pkg::CS_LOAD && !clk_out_o;
         sync_out_o <= master && state_reg != pcs_pkg::CS_LOAD && tim.start;
      end
   end

   assign status = {last_cnt_reg, 10'h000, ld_s2_reg, unsupported, ext_fail_reg,
      ext_ok_reg, state_reg};

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge sys_clk_i);
   endclocking
   default disable iff (rst_i);

   sequence s_good_interval;
      state_reg == pcs_pkg::CS_INT && want_ext && meas_done && win_ok;
   endsequence

   no_run_unsup_a: assert property (unsupported |-> !tim.run)
      else $error("switching with unsupported frequency");
   load_internal_a: assert property (state_reg == pcs_pkg::CS_LOAD |=> !main_clk_ext_o)
      else $error("external clock used before configuration load");
   switch_in_a: assert property (s_good_interval |=> main_clk_ext_o)
      else $error("qualified external clock not adopted");
   only_in_window_a: assert property ($rose(main_clk_ext_o) |-> $past(win_ok) &&
      $past(meas_done))
      else $error("external clock adopted outside window");
   stay_internal_a: assert property (state_reg == pcs_pkg::CS_INT && meas_done && !win_ok
      |=> !main_clk_ext_o)
      else $error("left internal clock without qualified input");
   fall_back_a: assert property (state_reg == pcs_pkg::CS_EXT && want_ext && auto_back
      && meas_done && !win_ok |=> state_reg == pcs_pkg::CS_INT ##1 !main_clk_ext_o)
      else $error("no switch back after external failure");
   master_quiet_a: assert property (state_reg == pcs_pkg::CS_LOAD
      && $past(state_reg) == pcs_pkg::CS_LOAD |-> !clk_out_o && !sync_out_o)
      else $error("master outputs before configuration load");
   slave_wait_a: assert property (!ld_s2_reg && state_reg == pcs_pkg::CS_LOAD
      |=> state_reg != pcs_pkg::CS_EXT)
      else $error("slave adopted master clock before load");
endmodule : pcs_top

// ---- test/pcs_ext_src.sv ----
// External clock source model for the clock synchronisation input.
`timescale 1ns/1ns
module pcs_ext_src (
   input wire logic en_i,              // Source running.
   input wire logic [15:0] half_ns_i,  // Half period in ns.
   output logic clk_o                  // External clock.
);
   // ----------------------------------------------------------------
   // Clock generation
   // ----------------------------------------------------------------
   // Toggles while enabled; a stopped source rests low, modelling a failed clock.
   initial begin
      clk_o = 1'b0;
      forever begin
         if (en_i) begin
            #(half_ns_i) clk_o = ~clk_o;
         end else begin
            clk_o = 1'b0;
            #10;
         end
      end
   end
endmodule : pcs_ext_src

// ---- test/pcs_top_test.sv ----
// Self-checking testbench of the switching clock controller.
`timescale 1ns/1ns
module pcs_top_test;
   logic sys_clk_i = 0, rst_i = 1, psel = 0, penable = 0, pwrite = 0;
   logic cfg_loaded_i = 0, ext_en = 0, err, pready, pslverr, ext_clk, acc;
   logic main_clk_ext_o, clk_out_o, sync_out_o;
   logic [31:0] paddr = 0, pwdata = 0, duty_cmd_i = 0, prdata, rd, lfsr = 32'h90FC;
   logic [3:0] hs_o, ls_o, clamped_o;
   logic [15:0] half_ns = 16'h00C8;
   int failures = 0, n_tests = 0, lim[4] = '{100, 47, 64, 85};
   pcs_top #(.MEAS_CYC(32)) i_pcs_top (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .cfg_loaded_i(cfg_loaded_i), .ext_clk_i(ext_clk),
      .duty_cmd_i(duty_cmd_i), .hs_o(hs_o), .ls_o(ls_o), .clamped_o(clamped_o),
      .main_clk_ext_o(main_clk_ext_o), .clk_out_o(clk_out_o), .sync_out_o(sync_out_o));
   pcs_ext_src i_pcs_ext_src (.en_i(ext_en), .half_ns_i(half_ns), .clk_o(ext_clk));
   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   // Clock of 100 ns period.
   initial begin
      forever #50 sys_clk_i = ~sys_clk_i;
   end
   task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
      n_tests++;
      if (s !== e) begin
         failures++;
         $display("mismatch %s expected %h seen %h", nm, e, s);
      end
   endtask : chk
   // One APB transfer; the request holds until pready is seen high.
   task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
      @(posedge sys_clk_i);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge sys_clk_i);
      penable <= 1'b1;
      do @(posedge sys_clk_i); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic wt(input logic v);
      for (int k = 0; k < 200 && main_clk_ext_o !== v; k++) @(posedge sys_clk_i);
   endtask : wt
   task automatic idle(input int n);
      acc = 1'b0;
      repeat (n) begin
         @(posedge sys_clk_i);
         acc = acc | main_clk_ext_o | clk_out_o | sync_out_o;
      end
   endtask : idle
   function automatic logic [31:0] nxt(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : nxt
   // Counts drive ticks over four periods and compares with the on-time model.
   task automatic pwm(input logic [7:0] fs, input logic [31:0] dc);
      int p, d, l, o, c;
      logic [15:0] hs[4], ls[4];
      logic [3:0] cl;
      p = 16 * (fs[2:0] + 1);
      apb(1, pcs_pkg::OFF_FREQ_SEL, {24'h0, fs});
      duty_cmd_i <= dc;
      // Let the old period, at most 128 ticks, run out before the new setting settles.
      repeat (3 * p + 128) @(posedge sys_clk_i);
      cl = 4'h0;
      hs = '{default: 16'h0};
      ls = '{default: 16'h0};
      repeat (4 * p) begin
         @(posedge sys_clk_i);
         cl = cl | clamped_o;
         for (int g = 0; g < 4; g++) begin
            hs[g] = hs[g] + hs_o[g];
            ls[g] = ls[g] + ls_o[g];
         end
      end
      for (int g = 0; g < 4; g++) begin
         d = dc[8*g+:8] * p / 256;
         l = lim[g] * p / 100;
         o = (d < l) ? d : l;
         c = (d >= l) || (o > p - 16);
         o = (o > p - 16) ? p - 16 : o;
         o = (o > 0 && o < 2) ? 2 : o;
         chk("hs_ticks", {16'h0, hs[g]}, 4 * o);
         chk("ls_ticks", {16'h0, ls[g]}, 4 * (p - o));
         chk("clamp", {31'h0, cl[g]}, c);
      end
   endtask : pwm
   task automatic conclude;
      if (failures == 0 && n_tests > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : conclude
   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   // Watchdog sized well beyond the expected run of about 4000 cycles.
   initial begin
      #3000000;
      failures++;
      conclude();
   end
   // Main sequence: registers, clock source selection, master outputs, PWM.
   initial begin
      repeat (12) @(posedge sys_clk_i);
      rst_i <= 1'b0;
      apb(0, pcs_pkg::OFF_FREQ_SEL, 0);
      chk("fsel_reset", rd, 32'h11);
      apb(0, 32'h24, 0);
      chk("unmapped", {31'h0, err}, 1);
      ext_en <= 1'b1;
      apb(1, pcs_pkg::OFF_EXP_CNT, 8);
      apb(1, pcs_pkg::OFF_WIN_PCT, 25);
      apb(1, pcs_pkg::OFF_SYNC_MODE, 32'hA);
      idle(150);
      chk("before_load", {31'h0, acc}, 0);
      cfg_loaded_i <= 1'b1;
      wt(1);
      chk("adopt_ext", {31'h0, main_clk_ext_o}, 1);
      acc = clk_out_o;
      @(posedge sys_clk_i);
      chk("fwd_clk", {31'h0, clk_out_o}, {31'h0, ~acc});
      for (int k = 0; k < 64 && sync_out_o !== 1'b1; k++) @(posedge sys_clk_i);
      chk("sync_out", {31'h0, sync_out_o}, 1);
      apb(1, pcs_pkg::OFF_SYNC_MODE, 32'h5);
      ext_en <= 1'b0;
      wt(0);
      chk("switch_back", {31'h0, main_clk_ext_o}, 0);
      apb(0, pcs_pkg::OFF_STATUS, 0);
      chk("ext_fail", {31'h0, rd[3]}, 1);
      // Start the fast clock with external use off, so no partial interval can qualify.
      apb(1, pcs_pkg::OFF_SYNC_MODE, 32'h4);
      half_ns = 16'h0064;
      ext_en <= 1'b1;
      repeat (40) @(posedge sys_clk_i);
      apb(1, pcs_pkg::OFF_SYNC_MODE, 32'h5);
      idle(150);
      apb(0, pcs_pkg::OFF_STATUS, 0);
      chk("out_of_win", {30'h0, acc, rd[1]}, 0);
      chk("int_state", {30'h0, rd[1:0]}, 1);
      half_ns = 16'h00C8;
      wt(1);
      chk("in_window", {31'h0, main_clk_ext_o}, 1);
      apb(1, pcs_pkg::OFF_SYNC_MODE, 0);
      wt(0);
      chk("int_select", {31'h0, main_clk_ext_o}, 0);
      for (int o = 0; o < 8; o++) begin
         apb(1, pcs_pkg::OFF_FREQ_SEL, (o << 4) | ((o == 0) ? 0 : 7));
         repeat (140) @(posedge sys_clk_i);
         apb(0, pcs_pkg::OFF_STATUS, 0);
         chk("unsupported", {31'h0, rd[4]}, (o == 0) || (o > 3));
      end
      for (int g = 0; g < 4; g++) apb(1, pcs_pkg::OFF_DUTY_LIM0 + 4 * g, lim[g]);
      pwm(8'h11, 32'h008008FF);
      for (int i = 0; i < 4; i++) begin
         lfsr = nxt(lfsr);
         pwm(i[0] ? 8'h03 : 8'h71, lfsr);
      end
      conclude();
   end
endmodule : pcs_top_test
